// >>> core/aso_core.sv
// Operand address generation and special sequences of the 8-bit core.
//
// Overview of operation
// - 0x0f is index pointer, 0x0e data window.
// - Window access redirects to pointer's direct-page byte.
// - Window usable by any direct/short/tiny operand.
// - Reset aborts the current instruction at once.
// - Classify reset cause, then hold clocks stopped.
// - Reset release loads start address and fetches.
// - Debug pin low at release enters background.
// - Background mode runs no user instructions.
// - Interrupts only wake; never redirect flow.
// - Wait/stop gate clocks until wake or reset.
// - Arithmetic shift left equals logical shift left.
// - Fetch and shadow pointers split six/eight bits.
// - Flag register holds zero and carry flags.
// - Four-bit operand addresses first sixteen bytes.
// - Five-bit operand addresses first thirty-two bytes.
// - Direct operand byte, high byte zero.
// - Long-jump bytes give six upper, eight lower.
// - Branch reach is signed eight-bit from next.
// - Bit number is three opcode bits.
// - Taken branch adds sign-extended offset to next fetch address.
`include "aso_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module aso_core (
    // Clock and reset
    input  wire logic                 CLK_IN,
    input  wire logic                 RST_N_IN,
    // Reset source, debug and wake
    input  wire logic                 RESET_EVENT_IN,
    input  wire logic                 RESET_EXT_IN,
    input  wire logic                 DEBUG_ENTRY_PIN_N_IN,
    input  wire logic                 HOST_BGND_REQ_IN,
    input  wire logic                 HOST_GO_IN,
    input  wire logic                 WAKE_IN,
    // Operation request
    input  wire aso_pkg::aso_op_t     OP_IN,
    output logic                      OP_READY_OUT,
    // Results and fetch
    output aso_pkg::aso_result_t      RESULT_OUT,
    output aso_pkg::aso_pc_t          FETCH_ADDR_OUT,
    output logic                      FETCH_REQ_OUT,
    output aso_pkg::aso_pc_t          SHADOW_OUT,
    // Status
    output logic                      CORE_CLK_EN_OUT,
    output logic                      BKGND_OUT,
    output logic                      SLEEP_OUT,
    output logic                      CAUSE_EXT_OUT
);
    import aso_pkg::*;

    // ======================================================================
    // Decoding helpers
    function automatic logic [13:0] calc_ea(input aso_mode_t m, input logic [7:0] opc,
                                            input logic [7:0] b1, input logic [7:0] b2);
        case (m)
            AM_FOUR_BIT:  calc_ea = {10'h000, opc[`ASO_TINY_MSB:0]};
            AM_FIVE_BIT:  calc_ea = {9'h000, opc[`ASO_SHORT_MSB:0]};
            AM_DIRECT:    calc_ea = {6'h00, b1};
            AM_LONG_JUMP: calc_ea = {b1[5:0], b2};
            default:      calc_ea = 14'h0000;
        endcase
    endfunction

    function automatic logic [13:0] sext8(input logic [7:0] v);
        sext8 = {{6{v[7]}}, v};
    endfunction

    // ======================================================================
    // State
    aso_state_t  state_q, state_d;
    aso_pc_t     pc_q, shadow_q;
    aso_result_t result_q;
    aso_kind_t   kind_q;
    logic [7:0]  x_q, addr_q;
    logic [2:0]  bitno_q;
    logic [7:0]  bit_mask;
    logic        ready_q, fetch_q, clk_en_q, cause_q, bkgnd_q, sleep_q;
    logic        take, release_now;
    logic [13:0] ea_raw, next_pc, br_tgt;
    logic [7:0]  ea_byte, mem_rdata, wr_addr, wr_data, new_val;
    logic        wr_en;

    assign take        = ready_q && OP_IN.valid && !RESET_EVENT_IN && !HOST_BGND_REQ_IN;
    assign release_now = (state_q == ST_CLASSIFY || state_q == ST_HOLD) && !RESET_EVENT_IN;
    assign ea_raw      = calc_ea(OP_IN.mode, OP_IN.opcode, OP_IN.opnd1, OP_IN.opnd2);
    // The window is resolved from the live pointer, so code may change it freely.
    assign ea_byte     = (ea_raw == `ASO_WINDOW_ADDR) ? x_q : ea_raw[7:0];
    assign next_pc     = pc_q + {12'h000, OP_IN.len};
    assign br_tgt      = next_pc + sext8(OP_IN.opnd1);

    for (genvar i = 0; i < 8; i++) begin : g_mask
        assign bit_mask[i] = (bitno_q == 3'(i));
    end

    // ======================================================================
    // Sequencer
    always_comb begin
        state_d = state_q;
        if (RESET_EVENT_IN) begin
            state_d = (state_q == ST_CLASSIFY || state_q == ST_HOLD) ? ST_HOLD : ST_CLASSIFY;
        end else begin
            case (state_q)
                ST_CLASSIFY, ST_HOLD: begin
                    state_d = DEBUG_ENTRY_PIN_N_IN ? ST_RUN : ST_BKGND;
                end
                ST_RUN: begin
                    if (HOST_BGND_REQ_IN) begin
                        state_d = ST_BKGND;
                    end else if (take) begin
                        case (OP_IN.kind)
                            K_READ, K_BSET, K_BCLR: state_d = ST_MEM;
                            K_LSL, K_ASL: state_d = (OP_IN.mode == AM_INH) ? ST_RUN : ST_MEM;
                            K_WAIT, K_STOP: state_d = ST_SLEEP;
                            K_BGND: state_d = ST_BKGND;
                            default: state_d = ST_RUN;
                        endcase
                    end
                end
                ST_MEM:   state_d = ST_RUN;
                ST_SLEEP: state_d = WAKE_IN ? ST_RUN : ST_SLEEP;
                ST_BKGND: state_d = HOST_GO_IN ? ST_RUN : ST_BKGND;
                default:  state_d = ST_CLASSIFY;
            endcase
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            state_q  <= ST_HOLD;
            ready_q  <= 1'b0;
            clk_en_q <= 1'b0;
            fetch_q  <= 1'b0;
            bkgnd_q  <= 1'b0;
            sleep_q  <= 1'b0;
        end else begin
            state_q  <= state_d;
            ready_q  <= (state_d == ST_RUN);
            // Clocks stop in reset hold and in sleep to save power.
            clk_en_q <= !(state_d == ST_HOLD || state_d == ST_SLEEP);
            fetch_q  <= (state_d == ST_RUN) && (state_q != ST_RUN || take);
            bkgnd_q  <= (state_d == ST_BKGND);
            sleep_q  <= (state_d == ST_SLEEP);
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            cause_q <= 1'b0;
        end else if (RESET_EVENT_IN && state_q != ST_CLASSIFY && state_q != ST_HOLD) begin
            cause_q <= RESET_EXT_IN;
        end
    end

    // ======================================================================
    // Fetch and shadow pointers
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            pc_q     <= `ASO_START_ADDR;
            shadow_q <= 14'h0000;
        end else if (RESET_EVENT_IN || release_now) begin
            pc_q <= `ASO_START_ADDR;
        end else if (take) begin
            case (OP_IN.kind)
                K_BRANCH: pc_q <= OP_IN.taken ? br_tgt : next_pc;
                K_JUMP: begin
                    pc_q     <= ea_raw;
                    shadow_q <= next_pc;
                end
                default: pc_q <= next_pc;
            endcase
        end
    end

    // ======================================================================
    // Direct-page access
    always_comb begin
        case (kind_q)
            K_BSET:       new_val = mem_rdata | bit_mask;
            K_BCLR:       new_val = mem_rdata & ~bit_mask;
            K_LSL, K_ASL: new_val = {mem_rdata[6:0], 1'b0};
            default:      new_val = mem_rdata;
        endcase
    end

    always_comb begin
        wr_en   = 1'b0;
        wr_addr = ea_byte;
        wr_data = OP_IN.wdata;
        if (state_q == ST_MEM && kind_q != K_READ && !RESET_EVENT_IN) begin
            wr_en   = 1'b1;
            wr_addr = addr_q;
            wr_data = new_val;
        end else if (take && OP_IN.kind == K_WRITE) begin
            wr_en = 1'b1;
        end
    end

    aso_dpram u_dpram (
        .clk_in    (CLK_IN),
        .rst_n_in  (RST_N_IN),
        .wr_en_in  (wr_en),
        .waddr_in  (wr_addr),
        .wdata_in  (wr_data),
        .raddr_in  (ea_byte),
        .rdata_out (mem_rdata)
    );

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            x_q <= `ASO_POINTER_RESET;
        end else if (wr_en && {6'h00, wr_addr} == `ASO_POINTER_ADDR) begin
            x_q <= wr_data;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            kind_q  <= K_NOP;
            addr_q  <= 8'h00;
            bitno_q <= 3'h0;
        end else if (take) begin
            kind_q  <= OP_IN.kind;
            addr_q  <= ea_byte;
            bitno_q <= OP_IN.opcode[`ASO_BITNO_LSB +: 3];
        end
    end

    // ======================================================================
    // Results and flags
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            result_q <= '0;
        end else begin
            result_q.valid <= 1'b0;
            if (RESET_EVENT_IN) begin
                result_q.valid <= 1'b0;
            end else if (state_q == ST_MEM) begin
                result_q.valid <= 1'b1;
                result_q.data  <= new_val;
                if (kind_q == K_READ || kind_q == K_LSL || kind_q == K_ASL) begin
                    result_q.zero <= (new_val == 8'h00);
                end
                if (kind_q == K_LSL || kind_q == K_ASL) begin
                    result_q.carry <= mem_rdata[7];
                end
            end else if (take && (OP_IN.kind == K_LSL || OP_IN.kind == K_ASL)
                         && OP_IN.mode == AM_INH) begin
                result_q.valid <= 1'b1;
                result_q.data  <= {OP_IN.wdata[6:0], 1'b0};
                result_q.zero  <= (OP_IN.wdata[6:0] == 7'h00);
                result_q.carry <= OP_IN.wdata[7];
            end
        end
    end

    assign OP_READY_OUT    = ready_q;
    assign RESULT_OUT      = result_q;
    assign FETCH_ADDR_OUT  = pc_q;
    assign FETCH_REQ_OUT   = fetch_q;
    assign SHADOW_OUT      = shadow_q;
    assign CORE_CLK_EN_OUT = clk_en_q;
    assign BKGND_OUT       = bkgnd_q;
    assign SLEEP_OUT       = sleep_q;
    assign CAUSE_EXT_OUT   = cause_q;

    // ======================================================================
    // Checks
    property p_window_redirect;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        (take && OP_IN.kind == K_READ && ea_raw == `ASO_WINDOW_ADDR) |=> (addr_q == $past(x_q));
    endproperty
    a_window_redirect: assert property (p_window_redirect) else $error("window not redirected");

    property p_reset_abort;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        RESET_EVENT_IN |=> (!OP_READY_OUT && !RESULT_OUT.valid && FETCH_ADDR_OUT == `ASO_START_ADDR);
    endproperty
    a_reset_abort: assert property (p_reset_abort) else $error("reset did not abort");

    property p_hold_clocks;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        (RESET_EVENT_IN [*3]) |-> !CORE_CLK_EN_OUT;
    endproperty
    a_hold_clocks: assert property (p_hold_clocks) else $error("clocks run in reset");

    property p_start_fetch;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        (release_now && DEBUG_ENTRY_PIN_N_IN) |=>
            (FETCH_REQ_OUT && FETCH_ADDR_OUT == `ASO_START_ADDR && CORE_CLK_EN_OUT);
    endproperty
    a_start_fetch: assert property (p_start_fetch) else $error("no fetch at start");

    property p_debug_entry;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        (release_now && !DEBUG_ENTRY_PIN_N_IN) |=> (BKGND_OUT && !FETCH_REQ_OUT && !OP_READY_OUT);
    endproperty
    a_debug_entry: assert property (p_debug_entry) else $error("no background entry");

    property p_wake_only;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        (state_q == ST_RUN && WAKE_IN && !take && !RESET_EVENT_IN) |=> $stable(FETCH_ADDR_OUT);
    endproperty
    a_wake_only: assert property (p_wake_only) else $error("interrupt moved fetch");

    property p_sleep;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        (take && (OP_IN.kind == K_WAIT || OP_IN.kind == K_STOP)) ##1 (!WAKE_IN && !RESET_EVENT_IN)
            |=> (SLEEP_OUT && !CORE_CLK_EN_OUT);
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep not held");

    property p_branch;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        (take && OP_IN.kind == K_BRANCH && OP_IN.taken) |=> (FETCH_ADDR_OUT == $past(br_tgt));
    endproperty
    a_branch: assert property (p_branch) else $error("bad branch target");

    property p_tiny;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        (take && OP_IN.mode == AM_FOUR_BIT && OP_IN.opcode[3:0] != 4'he) |=> (addr_q[7:4] == 4'h0);
    endproperty
    a_tiny: assert property (p_tiny) else $error("tiny address too high");

endmodule

`default_nettype wire

// >>> core/aso_defines.svh
// Constants of the addressing and special-operations unit.
`ifndef ASO_DEFINES_SVH
`define ASO_DEFINES_SVH

// ==========================================================================
// Memory map
`define ASO_WINDOW_ADDR    14'h000e
`define ASO_POINTER_ADDR   14'h000f
`define ASO_START_ADDR     14'h3ffd
`define ASO_DIRECT_TOP     14'h00ff
`define ASO_POINTER_RESET  8'h00

// ==========================================================================
// Opcode fields
`define ASO_TINY_MSB       3
`define ASO_SHORT_MSB      4
`define ASO_BITNO_LSB      1

`endif

// >>> core/aso_pkg.sv
// Types of the addressing and special-operations unit.
`default_nettype none

package aso_pkg;

    // ======================================================================
    // Operand encodings
    typedef enum logic [2:0] {
        AM_FOUR_BIT  = 3'b000,
        AM_FIVE_BIT  = 3'b001,
        AM_DIRECT    = 3'b010,
        AM_LONG_JUMP = 3'b011,
        AM_REL       = 3'b100,
        AM_INH       = 3'b101
    } aso_mode_t;

    // ======================================================================
    // Operation kinds
    typedef enum logic [3:0] {
        K_NOP    = 4'b0000,
        K_READ   = 4'b0001,
        K_WRITE  = 4'b0010,
        K_LSL    = 4'b0011,
        K_ASL    = 4'b0100,
        K_BSET   = 4'b0101,
        K_BCLR   = 4'b0110,
        K_BRANCH = 4'b0111,
        K_JUMP   = 4'b1000,
        K_WAIT   = 4'b1001,
        K_STOP   = 4'b1010,
        K_BGND   = 4'b1011
    } aso_kind_t;

    // ======================================================================
    // Sequencer states
    typedef enum logic [2:0] {
        ST_CLASSIFY = 3'b000,
        ST_HOLD     = 3'b001,
        ST_RUN      = 3'b010,
        ST_MEM      = 3'b011,
        ST_SLEEP    = 3'b100,
        ST_BKGND    = 3'b101
    } aso_state_t;

    // ======================================================================
    // Carriers
    typedef struct packed {
        logic [5:0] upper;
        logic [7:0] lower;
    } aso_pc_t;

    typedef struct packed {
        logic       valid;
        aso_kind_t  kind;
        aso_mode_t  mode;
        logic [7:0] opcode;
        logic [7:0] opnd1;
        logic [7:0] opnd2;
        logic [1:0] len;
        logic       taken;
        logic [7:0] wdata;
    } aso_op_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic       zero;
        logic       carry;
    } aso_result_t;

endpackage

`default_nettype wire

// >>> core/aso_dpram.sv
// Direct-page memory with registered read data.
`timescale 1ns/1ns
`default_nettype none

module aso_dpram (
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    // Write port
    input  wire logic       wr_en_in,
    input  wire logic [7:0] waddr_in,
    input  wire logic [7:0] wdata_in,
    // Read port
    input  wire logic [7:0] raddr_in,
    output logic      [7:0] rdata_out
);

    logic [7:0] mem_q [0:255];

    always_ff @(posedge clk_in) begin
        if (wr_en_in) begin
            mem_q[waddr_in] <= wdata_in;
        end
    end

    // A write and read of one location in one cycle returns the old byte.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            rdata_out <= 8'h00;
        end else begin
            rdata_out <= mem_q[raddr_in];
        end
    end

endmodule

`default_nettype wire

// >>> verif/aso_host_model.sv
// Debug host model that asks the core into and out of background mode.
`timescale 1ns/1ns
`default_nettype none

module aso_host_model (
    // Clock
    input  wire logic clk_in,
    // Commands from the bench
    input  wire logic halt_in,
    input  wire logic go_in,
    // Core side
    input  wire logic bkgnd_in,
    output var  logic bgnd_req_out,
    output var  logic go_out
);
    // ======================================================================
    // Requests
    // A request stands until the core shows the new mode, as a real host waits.
    always @(negedge clk_in) begin
        bgnd_req_out <= halt_in && !bkgnd_in;
        go_out <= go_in && bkgnd_in;
    end
endmodule
`default_nettype wire

// >>> verif/aso_core_tb_top.sv
// Self-checking bench of the addressing and special-operations core.
`timescale 1ns/1ns
`default_nettype none

module aso_core_tb_top;
    import aso_pkg::*;

    logic        CLK_IN, RST_N_IN, RESET_EVENT_IN, RESET_EXT_IN, DEBUG_ENTRY_PIN_N_IN;
    logic        HOST_BGND_REQ_IN, HOST_GO_IN, WAKE_IN, OP_READY_OUT, FETCH_REQ_OUT;
    logic        CORE_CLK_EN_OUT, BKGND_OUT, SLEEP_OUT, CAUSE_EXT_OUT, halt, go, t;
    aso_op_t     OP_IN;
    aso_result_t RESULT_OUT;
    aso_pc_t     FETCH_ADDR_OUT, SHADOW_OUT, exp_pc;
    logic [7:0]  v, p, o, b;
    logic [2:0]  n;
    int          error_cnt, num_checks, seed, i;

    aso_core DUT (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .RESET_EVENT_IN(RESET_EVENT_IN),
        .RESET_EXT_IN(RESET_EXT_IN), .DEBUG_ENTRY_PIN_N_IN(DEBUG_ENTRY_PIN_N_IN),
        .HOST_BGND_REQ_IN(HOST_BGND_REQ_IN), .HOST_GO_IN(HOST_GO_IN), .WAKE_IN(WAKE_IN),
        .OP_IN(OP_IN), .OP_READY_OUT(OP_READY_OUT), .RESULT_OUT(RESULT_OUT),
        .FETCH_ADDR_OUT(FETCH_ADDR_OUT), .FETCH_REQ_OUT(FETCH_REQ_OUT), .SHADOW_OUT(SHADOW_OUT),
        .CORE_CLK_EN_OUT(CORE_CLK_EN_OUT), .BKGND_OUT(BKGND_OUT), .SLEEP_OUT(SLEEP_OUT),
        .CAUSE_EXT_OUT(CAUSE_EXT_OUT));

    aso_host_model host (.clk_in(CLK_IN), .halt_in(halt), .go_in(go), .bkgnd_in(BKGND_OUT),
        .bgnd_req_out(HOST_BGND_REQ_IN), .go_out(HOST_GO_IN));

    initial begin
        CLK_IN = 1'b0;
        forever #5 CLK_IN = ~CLK_IN;
    end

    // ======================================================================
    // Checking
    task automatic stop_test();
        if (error_cnt == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic fail(input logic [13:0] got, input logic [13:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        fail({6'h00, got}, {6'h00, exp});
    endtask

    task automatic chk_addr(input aso_pc_t got, input aso_pc_t exp);
        fail(got, exp);
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        fail({13'h0000, got}, {13'h0000, exp});
    endtask

    // Branch target wraps in fourteen bits because the sum is truncated.
    function automatic aso_pc_t br_target(input aso_pc_t pc, input logic [7:0] off,
                                          input logic tk);
        return pc + 14'd2 + (tk ? {{6{off[7]}}, off} : 14'h0000);
    endfunction

    // ======================================================================
    // Drivers
    task automatic wait_lvl(input int which, input logic lvl);
        logic s;
        for (int k = 0; k < 60; k++) begin
            case (which)
                0: s = OP_READY_OUT;
                1: s = BKGND_OUT;
                2: s = SLEEP_OUT;
                default: s = RESULT_OUT.valid;
            endcase
            if (s === lvl) return;
            @(negedge CLK_IN);
        end
        error_cnt++;
        stop_test();
    endtask

    task automatic run_op(input aso_kind_t k, input aso_mode_t m, input logic [7:0] opc, o1,
                          o2, input logic [1:0] len, input logic tk, input logic [7:0] wd);
        wait_lvl(0, 1'b1);
        OP_IN = '{1'b1, k, m, opc, o1, o2, len, tk, wd};
        @(negedge CLK_IN);
        OP_IN.valid = 1'b0;
    endtask

    // A gap follows every memory op so that no read meets the write before it.
    task automatic settle();
        wait_lvl(0, 1'b1);
        exp_pc = exp_pc + 14'd2;
        chk_addr(FETCH_ADDR_OUT, exp_pc);
        repeat (2) @(negedge CLK_IN);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        run_op(K_WRITE, AM_DIRECT, 8'h00, a, 8'h00, 2'd2, 1'b0, d);
        settle();
    endtask

    task automatic mop(input aso_kind_t k, input aso_mode_t m, input logic [7:0] opc, a, e);
        run_op(k, m, opc, a, 8'h00, 2'd2, 1'b0, 8'h00);
        wait_lvl(3, 1'b1);
        chk_byte(RESULT_OUT.data, e);
        if (k != K_BSET && k != K_BCLR) chk_bit(RESULT_OUT.zero, e == 8'h00);
        settle();
    endtask

    task automatic jmp();
        o = 8'($random(seed)) & 8'h3f;
        v = 8'($random(seed));
        run_op(K_JUMP, AM_LONG_JUMP, 8'hbc, o, v, 2'd3, 1'b0, 8'h00);
        @(negedge CLK_IN);
        chk_addr(SHADOW_OUT, exp_pc + 14'd3);
        exp_pc = {o[5:0], v};
        chk_addr(FETCH_ADDR_OUT, exp_pc);
    endtask

    // ======================================================================
    // Scenarios
    initial begin
        seed = 92708;
        error_cnt = 0;
        num_checks = 0;
        {RESET_EVENT_IN, RESET_EXT_IN, WAKE_IN, halt, go} = '0;
        DEBUG_ENTRY_PIN_N_IN = 1'b1;
        OP_IN = '0;
        RST_N_IN = 1'b0;
        repeat (12) @(negedge CLK_IN);
        RST_N_IN = 1'b1;
        wait_lvl(0, 1'b1);
        exp_pc = 14'h3ffd;
        chk_addr(FETCH_ADDR_OUT, exp_pc);
        chk_bit(FETCH_REQ_OUT, 1'b1);
        chk_bit(BKGND_OUT, 1'b0);
        for (i = 0; i < 8; i++) begin
            p = {3'b001, 5'($random(seed))};
            v = (i == 0) ? 8'h00 : 8'($random(seed));
            n = 3'(i);
            b = 8'h01 << n;
            wr(8'h0f, p);
            wr(8'h0e, v);
            mop(K_READ, AM_FOUR_BIT, 8'hfe, 8'h00, v);
            mop(K_READ, AM_FIVE_BIT, 8'hee, 8'h00, v);
            mop(K_READ, AM_DIRECT, 8'h00, p, v);
            mop(i[0] ? K_ASL : K_LSL, AM_DIRECT, 8'h00, p, v << 1);
            chk_bit(RESULT_OUT.carry, v[7]);
            wr(p, v);
            mop(K_BSET, AM_DIRECT, {4'h1, n, 1'b0}, p, v | b);
            mop(K_BCLR, AM_DIRECT, {4'h1, n, 1'b1}, p, v & ~b);
            mop(K_READ, AM_DIRECT, 8'h00, p, v & ~b);
        end
        for (i = 0; i < 6; i++) begin
            v = 8'($random(seed));
            o = (i < 2) ? {i[0], {7{~i[0]}}} : v;
            t = (i < 2) | v[1];
            run_op(K_BRANCH, AM_REL, 8'h37, o, 8'h00, 2'd2, t, 8'h00);
            @(negedge CLK_IN);
            exp_pc = br_target(exp_pc, o, t);
            chk_addr(FETCH_ADDR_OUT, exp_pc);
        end
        jmp();
        for (i = 0; i < 2; i++) begin
            run_op(i[0] ? K_STOP : K_WAIT, AM_INH, 8'h00, 8'h00, 8'h00, 2'd1, 1'b0, 8'h00);
            exp_pc = exp_pc + 14'd1;
            repeat (4) @(negedge CLK_IN);
            chk_bit(SLEEP_OUT, 1'b1);
            chk_bit(CORE_CLK_EN_OUT, 1'b0);
            WAKE_IN = 1'b1;
            wait_lvl(2, 1'b0);
            WAKE_IN = 1'b0;
            chk_bit(FETCH_REQ_OUT, 1'b1);
            chk_addr(FETCH_ADDR_OUT, exp_pc);
            chk_bit(BKGND_OUT, 1'b0);
        end
        // Corner: a shift of 0x80 in the accumulator form leaves zero and carries out.
        v = 8'h80;
        run_op(K_ASL, AM_INH, 8'h48, 8'h00, 8'h00, 2'd1, 1'b0, v);
        chk_bit(RESULT_OUT.valid, 1'b1);
        chk_byte(RESULT_OUT.data, 8'h00);
        chk_bit(RESULT_OUT.zero, 1'b1);
        chk_bit(RESULT_OUT.carry, 1'b1);
        exp_pc = exp_pc + 14'd1;
        @(negedge CLK_IN);
        run_op(K_BGND, AM_INH, 8'hbf, 8'h00, 8'h00, 2'd1, 1'b0, 8'h00);
        chk_bit(BKGND_OUT, 1'b1);
        go = 1'b1;
        wait_lvl(1, 1'b0);
        go = 1'b0;
        exp_pc = exp_pc + 14'd1;
        chk_addr(FETCH_ADDR_OUT, exp_pc);
        jmp();
        WAKE_IN = 1'b1;
        repeat (3) @(negedge CLK_IN);
        WAKE_IN = 1'b0;
        chk_addr(FETCH_ADDR_OUT, exp_pc);
        chk_bit(SLEEP_OUT, 1'b0);
        halt = 1'b1;
        wait_lvl(1, 1'b1);
        halt = 1'b0;
        OP_IN = '{1'b1, K_WRITE, AM_DIRECT, 8'h00, 8'h0f, 8'h00, 2'd2, 1'b0, 8'h55};
        repeat (3) @(negedge CLK_IN);
        chk_bit(OP_READY_OUT, 1'b0);
        OP_IN.valid = 1'b0;
        chk_addr(FETCH_ADDR_OUT, exp_pc);
        go = 1'b1;
        wait_lvl(1, 1'b0);
        go = 1'b0;
        mop(K_READ, AM_DIRECT, 8'h00, 8'h0f, p);
        run_op(K_READ, AM_DIRECT, 8'h00, p, 8'h00, 2'd2, 1'b0, 8'h00);
        RESET_EXT_IN = 1'b1;
        RESET_EVENT_IN = 1'b1;
        for (i = 0; i < 4; i++) begin
            @(negedge CLK_IN);
            chk_bit(RESULT_OUT.valid, 1'b0);
        end
        chk_bit(CORE_CLK_EN_OUT, 1'b0);
        chk_bit(CAUSE_EXT_OUT, 1'b1);
        RESET_EVENT_IN = 1'b0;
        RESET_EXT_IN = 1'b0;
        wait_lvl(0, 1'b1);
        chk_addr(FETCH_ADDR_OUT, 14'h3ffd);
        chk_bit(FETCH_REQ_OUT, 1'b1);
        DEBUG_ENTRY_PIN_N_IN = 1'b0;
        RST_N_IN = 1'b0;
        repeat (12) @(negedge CLK_IN);
        RST_N_IN = 1'b1;
        repeat (2) @(negedge CLK_IN);
        chk_bit(BKGND_OUT, 1'b1);
        chk_bit(OP_READY_OUT, 1'b0);
        DEBUG_ENTRY_PIN_N_IN = 1'b1;
        go = 1'b1;
        wait_lvl(1, 1'b0);
        go = 1'b0;
        chk_addr(FETCH_ADDR_OUT, 14'h3ffd);
        stop_test();
    end
endmodule
`default_nettype wire
